// ==== design/pin_mux_pkg.sv ====
// Package: register map, field layout, codes and carriers of the port A/B/C pin function mux
package pin_mux_pkg;

  // ==========================================================================
  // Package variants
  // ==========================================================================
  typedef enum logic [1:0] {
    VAR_SMALL,                               // Fewest pins
    VAR_MEDIUM,                              // Middle package
    VAR_LARGE                                // Most pins
  } variant_t;

  // ==========================================================================
  // Register byte addresses (word aligned)
  // ==========================================================================
  localparam int          ADDR_W        = 8;        // Decoded address bits
  localparam logic [7:0]  OFS_PA_LOW    = 8'h00;    // porta_low_function_select
  localparam logic [7:0]  OFS_PA_HIGH   = 8'h04;    // porta_high_function_select
  localparam logic [7:0]  OFS_PB_LOW    = 8'h08;    // portb_low_function_select
  localparam logic [7:0]  OFS_PB_HIGH   = 8'h0C;    // portb_high_function_select_*
  localparam logic [7:0]  OFS_PC_LOW    = 8'h10;    // portc_low_function_select_large
  localparam logic [7:0]  OFS_PC_HIGH   = 8'h14;    // portc_high_function_select_*

  // ==========================================================================
  // Reset value and implemented-bit masks
  // ==========================================================================
  localparam logic [7:0]  RST_SEL          = 8'h00; // Every field clears to I/O
  localparam logic [7:0]  MASK_PA_LOW      = 8'hFC; // Bits 1:0 absent
  localparam logic [7:0]  MASK_PA_HIGH     = 8'h3F; // Bits 7:6 absent
  localparam logic [7:0]  MASK_PB_LOW      = 8'hFF; // All bits stored
  localparam logic [7:0]  MASK_PB_HIGH_S   = 8'h03; // Pin 4 only
  localparam logic [7:0]  MASK_PB_HIGH_M   = 8'h33; // Pins 4 and 6
  localparam logic [7:0]  MASK_PB_HIGH_L   = 8'hFF; // Pins 4 to 7
  localparam logic [7:0]  MASK_PC_LOW_L    = 8'hFF; // Pins 0 to 3
  localparam logic [7:0]  MASK_NONE        = 8'h00; // Register absent
  localparam logic [7:0]  MASK_PC_HIGH_S   = 8'h0F; // Pins 4 and 5
  localparam logic [7:0]  MASK_PC_HIGH_M   = 8'h3F; // Pins 4 to 6
  localparam logic [7:0]  MASK_PC_HIGH_L   = 8'hFF; // Pins 4 to 7

  // ==========================================================================
  // Field positions and selection codes
  // ==========================================================================
  localparam int          FIELD_W       = 2;        // Width of one pin field
  localparam int          FLD_HI        = 6;        // Bits 7:6
  localparam int          FLD_MH        = 4;        // Bits 5:4
  localparam int          FLD_ML        = 2;        // Bits 3:2
  localparam int          FLD_LO        = 0;        // Bits 1:0
  localparam logic [1:0]  SEL_PERIPH    = 2'h2;     // Digital peripheral
  localparam logic [1:0]  SEL_ALT       = 2'h3;     // Comparator or analog

  // ==========================================================================
  // AHB-Lite constants
  // ==========================================================================
  localparam int          DATA_W        = 32;       // Bus data width
  localparam int          REG_W         = 8;        // Register width
  localparam int          ANALOG_N      = 16;       // Analog enable vector width
  localparam logic        HRESP_OKAY    = 1'b0;     // Only answer given

  // ==========================================================================
  // Output carriers
  // ==========================================================================
  typedef struct packed {
    logic serial_clock_pin;                  // Port A pin 3
    logic serial_data_in_pin;                // Port A pin 2
    logic serial_data_out_pin;               // Port A pin 1
    logic comparator0_inverting_input;       // Port A pin 3
    logic comparator0_noninverting_input;    // Port A pin 2
    logic comparator0_output;                // Port A pin 1
    logic comparator1_inverting_input;       // Port A pin 6
    logic standard_timer_clock_input;        // Port A pin 6
    logic periodic_timer0_capture_input;     // Port A pin 5
    logic periodic_timer0_output;            // Port A pin 5
    logic standard_timer_capture_input;      // Port B pin 4
    logic standard_timer_output;             // Port B pin 4
    logic external_interrupt1_input;         // Port B pin 6, large only
    logic uart_receive;                      // Port C pin 5
    logic uart_transmit;                     // Port C pin 4
  } pin_roles_t;

  typedef struct packed {
    logic [7:0] porta;                       // General I/O per pin
    logic [7:0] portb;
    logic [7:0] portc;
  } gpio_map_t;

  localparam gpio_map_t GPIO_RST = '{porta: 8'hFF, portb: 8'hFF, portc: 8'hFF};

endpackage

// ==== design/port_abc_function_select_mux.sv ====
// Top: AHB-Lite register slave and pin role decoder for ports A, B and C
//
// Contract
// - PA low 7:6/5:4: I/O, serial, comparator 0
// - PA low 3:2: I/O, serial out, comp0 out
// - PA high 5:4: I/O+timer clock, comp1 input
// - PA high 3:2: I/O+capture, periodic timer output
// - PB high 1:0: I/O+capture, timer out, AN4
// - Medium PB high 5:4: I/O or AN5
// - Large PB high 7:6/3:2: AN7, AN5
// - Large PB high 5:4: I/O+interrupt1 or AN6
// - Large PC low fields: I/O or ANALOG_CHANNEL_11..AN8
// - Small PC high: UART pins, AN6, AN5
// - Medium PC high 5:4: I/O or AN8
// - Medium PC high: UART pins, AN7, AN6
// - Unimplemented bits always read zero
//
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module port_abc_function_select_mux #(
  parameter pin_mux_pkg::variant_t VARIANT = pin_mux_pkg::VAR_LARGE
) (
  // Clock and reset
  input  wire logic                         REF_CLK,
  input  wire logic                         RST,
  // AHB-Lite slave
  input  wire logic                         HSEL,
  input  wire logic [31:0]                  HADDR,
  input  wire logic [1:0]                   HTRANS,
  input  wire logic                         HWRITE,
  input  wire logic [2:0]                   HSIZE,
  input  wire logic [31:0]                  HWDATA,
  input  wire logic                         HREADY,
  output logic      [31:0]                  HRDATA,
  output logic                              HREADYOUT,
  output logic                              HRESP,
  // Pin roles
  output pin_mux_pkg::pin_roles_t           PIN_ROLES,
  output logic      [15:0]                  ANALOG_EN,
  output pin_mux_pkg::gpio_map_t            GPIO_EN
);

  // ==========================================================================
  // Variant flags and masks
  // ==========================================================================
  localparam logic       IS_S = (VARIANT == pin_mux_pkg::VAR_SMALL);  // Small
  localparam logic       IS_M = (VARIANT == pin_mux_pkg::VAR_MEDIUM); // Medium
  localparam logic       IS_L = (VARIANT == pin_mux_pkg::VAR_LARGE);  // Large
  localparam logic [7:0] M_PBH = IS_S ? pin_mux_pkg::MASK_PB_HIGH_S :
                                 IS_M ? pin_mux_pkg::MASK_PB_HIGH_M :
                                        pin_mux_pkg::MASK_PB_HIGH_L;
  localparam logic [7:0] M_PCL = IS_L ? pin_mux_pkg::MASK_PC_LOW_L :
                                        pin_mux_pkg::MASK_NONE;
  localparam logic [7:0] M_PCH = IS_S ? pin_mux_pkg::MASK_PC_HIGH_S :
                                 IS_M ? pin_mux_pkg::MASK_PC_HIGH_M :
                                        pin_mux_pkg::MASK_PC_HIGH_L;

  // ==========================================================================
  // Bus address and data phase tracking
  // ==========================================================================
  logic                  wr_pend_q;         // Write data phase in progress
  logic [7:0]            wr_addr_q;         // Address of pending write
  logic [7:0]            wdat;              // Low byte of write data
  logic                  accept;            // Address phase taken
  logic [7:0]            aaddr;             // Decoded address bits

  // Transfer taken when selected, bus ready and NONSEQ/SEQ
  assign accept = HSEL && HREADY && HTRANS[1];
  assign aaddr  = HADDR[pin_mux_pkg::ADDR_W-1:0];
  assign wdat   = HWDATA[pin_mux_pkg::REG_W-1:0];

  // Remember a write until its data phase
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= accept && HWRITE;
      wr_addr_q <= accept ? aaddr : wr_addr_q;
    end
  end

  // ==========================================================================
  // Selection registers
  // ==========================================================================
  logic [7:0] pa_low_q,  pa_low_d;         // porta_low_function_select
  logic [7:0] pa_high_q, pa_high_d;        // porta_high_function_select
  logic [7:0] pb_low_q,  pb_low_d;         // portb_low_function_select
  logic [7:0] pb_high_q, pb_high_d;        // portb_high_function_select
  logic [7:0] pc_low_q,  pc_low_d;         // portc_low_function_select
  logic [7:0] pc_high_q, pc_high_d;        // portc_high_function_select
  logic       hit_pal, hit_pah, hit_pbl;   // Write hits per register
  logic       hit_pbh, hit_pcl, hit_pch;

  // Write strobes in the data phase
  assign hit_pal = wr_pend_q && (wr_addr_q == pin_mux_pkg::OFS_PA_LOW);
  assign hit_pah = wr_pend_q && (wr_addr_q == pin_mux_pkg::OFS_PA_HIGH);
  assign hit_pbl = wr_pend_q && (wr_addr_q == pin_mux_pkg::OFS_PB_LOW);
  assign hit_pbh = wr_pend_q && (wr_addr_q == pin_mux_pkg::OFS_PB_HIGH);
  assign hit_pcl = wr_pend_q && (wr_addr_q == pin_mux_pkg::OFS_PC_LOW);
  assign hit_pch = wr_pend_q && (wr_addr_q == pin_mux_pkg::OFS_PC_HIGH);

  // Next values; masks keep absent bits at zero
  assign pa_low_d  = hit_pal ? (wdat & pin_mux_pkg::MASK_PA_LOW)  : pa_low_q;
  assign pa_high_d = hit_pah ? (wdat & pin_mux_pkg::MASK_PA_HIGH) : pa_high_q;
  assign pb_low_d  = hit_pbl ? (wdat & pin_mux_pkg::MASK_PB_LOW)  : pb_low_q;
  assign pb_high_d = hit_pbh ? (wdat & M_PBH) : pb_high_q;
  assign pc_low_d  = hit_pcl ? (wdat & M_PCL) : pc_low_q;
  assign pc_high_d = hit_pch ? (wdat & M_PCH) : pc_high_q;

  // Register update, cleared on reset
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pa_low_q  <= pin_mux_pkg::RST_SEL;
      pa_high_q <= pin_mux_pkg::RST_SEL;
      pb_low_q  <= pin_mux_pkg::RST_SEL;
      pb_high_q <= pin_mux_pkg::RST_SEL;
      pc_low_q  <= pin_mux_pkg::RST_SEL;
      pc_high_q <= pin_mux_pkg::RST_SEL;
    end else begin
      pa_low_q  <= pa_low_d;
      pa_high_q <= pa_high_d;
      pb_low_q  <= pb_low_d;
      pb_high_q <= pb_high_d;
      pc_low_q  <= pc_low_d;
      pc_high_q <= pc_high_d;
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  logic [7:0] rd_byte;                     // Selected register, post-write value

  // Unmapped addresses read zero; a write in flight is forwarded
  assign rd_byte = (aaddr == pin_mux_pkg::OFS_PA_LOW)  ? pa_low_d  :
                   (aaddr == pin_mux_pkg::OFS_PA_HIGH) ? pa_high_d :
                   (aaddr == pin_mux_pkg::OFS_PB_LOW)  ? pb_low_d  :
                   (aaddr == pin_mux_pkg::OFS_PB_HIGH) ? pb_high_d :
                   (aaddr == pin_mux_pkg::OFS_PC_LOW)  ? pc_low_d  :
                   (aaddr == pin_mux_pkg::OFS_PC_HIGH) ? pc_high_d : 8'h00;

  // Bus answer: zero wait, always OKAY, data held until next read
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= pin_mux_pkg::HRESP_OKAY;
    end else begin
      HRDATA    <= (accept && !HWRITE) ? {24'h00_0000, rd_byte} : HRDATA;
      HREADYOUT <= 1'b1;
      HRESP     <= pin_mux_pkg::HRESP_OKAY;
    end
  end

  // ==========================================================================
  // Field extraction
  // ==========================================================================
  logic [1:0] pa3, pa2, pa1, pa6, pa5;     // Port A fields
  logic [1:0] pb4, pb5, pb6, pb7;          // Port B fields
  logic [1:0] pc0, pc1, pc2, pc3;          // Port C low fields
  logic [1:0] pc4, pc5, pc6;               // Port C high fields

  assign pa3 = pa_low_q[pin_mux_pkg::FLD_HI +: pin_mux_pkg::FIELD_W];
  assign pa2 = pa_low_q[pin_mux_pkg::FLD_MH +: pin_mux_pkg::FIELD_W];
  assign pa1 = pa_low_q[pin_mux_pkg::FLD_ML +: pin_mux_pkg::FIELD_W];
  assign pa6 = pa_high_q[pin_mux_pkg::FLD_MH +: pin_mux_pkg::FIELD_W];
  assign pa5 = pa_high_q[pin_mux_pkg::FLD_ML +: pin_mux_pkg::FIELD_W];
  assign pb7 = pb_high_q[pin_mux_pkg::FLD_HI +: pin_mux_pkg::FIELD_W];
  assign pb6 = pb_high_q[pin_mux_pkg::FLD_MH +: pin_mux_pkg::FIELD_W];
  assign pb5 = pb_high_q[pin_mux_pkg::FLD_ML +: pin_mux_pkg::FIELD_W];
  assign pb4 = pb_high_q[pin_mux_pkg::FLD_LO +: pin_mux_pkg::FIELD_W];
  assign pc3 = pc_low_q[pin_mux_pkg::FLD_HI +: pin_mux_pkg::FIELD_W];
  assign pc2 = pc_low_q[pin_mux_pkg::FLD_MH +: pin_mux_pkg::FIELD_W];
  assign pc1 = pc_low_q[pin_mux_pkg::FLD_ML +: pin_mux_pkg::FIELD_W];
  assign pc0 = pc_low_q[pin_mux_pkg::FLD_LO +: pin_mux_pkg::FIELD_W];
  assign pc6 = pc_high_q[pin_mux_pkg::FLD_MH +: pin_mux_pkg::FIELD_W];
  assign pc5 = pc_high_q[pin_mux_pkg::FLD_ML +: pin_mux_pkg::FIELD_W];
  assign pc4 = pc_high_q[pin_mux_pkg::FLD_LO +: pin_mux_pkg::FIELD_W];

  // ==========================================================================
  // Role decode
  // ==========================================================================
  pin_mux_pkg::pin_roles_t roles_d;        // Decoded digital roles
  logic [15:0]             analog_d;       // Decoded analog channels
  pin_mux_pkg::gpio_map_t  gpio_d;         // Decoded general I/O pins
  logic                    pa3_io, pa2_io, pa1_io, pa5_io, pb4_io; // 00/01 codes
  logic                    uart_pins;      // Variants with UART on port C high

  assign pa3_io    = !pa3[1];
  assign pa2_io    = !pa2[1];
  assign pa1_io    = !pa1[1];
  assign pa5_io    = !pa5[1];
  assign pb4_io    = !pb4[1];
  assign uart_pins = IS_S || IS_M;

  // Port A serial and comparator roles
  assign roles_d.serial_clock_pin              = (pa3 == pin_mux_pkg::SEL_PERIPH);
  assign roles_d.comparator0_inverting_input   = (pa3 == pin_mux_pkg::SEL_ALT);
  assign roles_d.serial_data_in_pin            = (pa2 == pin_mux_pkg::SEL_PERIPH);
  assign roles_d.comparator0_noninverting_input = (pa2 == pin_mux_pkg::SEL_ALT);
  assign roles_d.serial_data_out_pin           = (pa1 == pin_mux_pkg::SEL_PERIPH);
  assign roles_d.comparator0_output            = (pa1 == pin_mux_pkg::SEL_ALT);
  // Port A timer and comparator 1 roles
  assign roles_d.comparator1_inverting_input   = (pa6 == pin_mux_pkg::SEL_ALT);
  assign roles_d.standard_timer_clock_input    = (pa6 != pin_mux_pkg::SEL_ALT);
  assign roles_d.periodic_timer0_capture_input = pa5_io;
  assign roles_d.periodic_timer0_output        = (pa5 == pin_mux_pkg::SEL_PERIPH);
  // Port B timer and interrupt roles
  assign roles_d.standard_timer_capture_input  = pb4_io;
  assign roles_d.standard_timer_output         = (pb4 == pin_mux_pkg::SEL_PERIPH);
  assign roles_d.external_interrupt1_input     = IS_L && (pb6 != pin_mux_pkg::SEL_ALT);
  // Port C UART roles
  assign roles_d.uart_receive  = uart_pins && (pc5 == pin_mux_pkg::SEL_PERIPH);
  assign roles_d.uart_transmit = uart_pins && (pc4 == pin_mux_pkg::SEL_PERIPH);

  // Analog channel enables per variant
  always_comb begin
    analog_d     = 16'h0000;
    analog_d[4]  = (pb4 == pin_mux_pkg::SEL_ALT);
    analog_d[5]  = (IS_M && pb6 == pin_mux_pkg::SEL_ALT)
                || (IS_L && pb5 == pin_mux_pkg::SEL_ALT)
                || (IS_S && pc4 == pin_mux_pkg::SEL_ALT);
    analog_d[6]  = (IS_L && pb6 == pin_mux_pkg::SEL_ALT)
                || (IS_S && pc5 == pin_mux_pkg::SEL_ALT)
                || (IS_M && pc4 == pin_mux_pkg::SEL_ALT);
    analog_d[7]  = (IS_L && pb7 == pin_mux_pkg::SEL_ALT)
                || (IS_M && pc5 == pin_mux_pkg::SEL_ALT);
    analog_d[8]  = (IS_M && pc6 == pin_mux_pkg::SEL_ALT)
                || (IS_L && pc0 == pin_mux_pkg::SEL_ALT);
    analog_d[9]  = IS_L && (pc1 == pin_mux_pkg::SEL_ALT);
    analog_d[10] = IS_L && (pc2 == pin_mux_pkg::SEL_ALT);
    analog_d[11] = IS_L && (pc3 == pin_mux_pkg::SEL_ALT);
  end

  // General I/O flags; undecoded pins stay I/O
  always_comb begin
    gpio_d          = pin_mux_pkg::GPIO_RST;
    gpio_d.porta[3] = pa3_io;
    gpio_d.porta[2] = pa2_io;
    gpio_d.porta[1] = pa1_io;
    gpio_d.porta[6] = (pa6 != pin_mux_pkg::SEL_ALT);
    gpio_d.porta[5] = pa5_io;
    gpio_d.portb[4] = pb4_io;
    gpio_d.portb[6] = IS_S || (pb6 != pin_mux_pkg::SEL_ALT);
    gpio_d.portb[5] = !IS_L || (pb5 != pin_mux_pkg::SEL_ALT);
    gpio_d.portb[7] = !IS_L || (pb7 != pin_mux_pkg::SEL_ALT);
    gpio_d.portc[0] = !IS_L || (pc0 != pin_mux_pkg::SEL_ALT);
    gpio_d.portc[1] = !IS_L || (pc1 != pin_mux_pkg::SEL_ALT);
    gpio_d.portc[2] = !IS_L || (pc2 != pin_mux_pkg::SEL_ALT);
    gpio_d.portc[3] = !IS_L || (pc3 != pin_mux_pkg::SEL_ALT);
    gpio_d.portc[4] = !uart_pins || !pc4[1];
    gpio_d.portc[5] = !uart_pins || !pc5[1];
    gpio_d.portc[6] = !IS_M || (pc6 != pin_mux_pkg::SEL_ALT);
  end

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      PIN_ROLES <= '0;
      ANALOG_EN <= 16'h0000;
      GPIO_EN   <= pin_mux_pkg::GPIO_RST;
    end else begin
      PIN_ROLES <= roles_d;
      ANALOG_EN <= analog_d;
      GPIO_EN   <= gpio_d;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  AST_PA3_SERIAL_CLOCK: assert property (
    (pa3 == pin_mux_pkg::SEL_PERIPH) |=> (PIN_ROLES.serial_clock_pin && !GPIO_EN.porta[3]))
    else $error("pin 3 serial clock role missing");
  AST_PA2_COMPARATOR: assert property (
    (pa2 == pin_mux_pkg::SEL_ALT) |=> (PIN_ROLES.comparator0_noninverting_input
                                      && !PIN_ROLES.serial_data_in_pin))
    else $error("pin 2 comparator role wrong");
  AST_PA1_OUTPUT: assert property (
    $changed(pa1) |=> (PIN_ROLES.comparator0_output == ($past(pa1) == pin_mux_pkg::SEL_ALT)))
    else $error("pin 1 comparator output does not follow field");
  AST_PA6_TIMER_CLOCK: assert property (
    (!RST && pa6 != pin_mux_pkg::SEL_ALT) [*2] |-> PIN_ROLES.standard_timer_clock_input)
    else $error("timer clock input lost on pin 6");
  AST_PA5_TIMER_OUT: assert property (
    (pa5 == pin_mux_pkg::SEL_PERIPH) |=> (PIN_ROLES.periodic_timer0_output
                                         && !PIN_ROLES.periodic_timer0_capture_input))
    else $error("periodic timer output not routed");
  AST_PB4_ANALOG: assert property (
    (pb4 == pin_mux_pkg::SEL_ALT) |=> (ANALOG_EN[4] && !PIN_ROLES.standard_timer_output))
    else $error("analog channel 4 not enabled");
  AST_PC_LARGE_ANALOG: assert property (
    (IS_L && pc3 == pin_mux_pkg::SEL_ALT) |=> ANALOG_EN[11])
    else $error("analog channel 11 not enabled");
  AST_RSVD_READ_ZERO: assert property (
    (accept && !HWRITE && aaddr == pin_mux_pkg::OFS_PA_LOW) |=> (HRDATA[1:0] == 2'h0))
    else $error("unimplemented bits read nonzero");
  AST_WRITE_READBACK: assert property (
    hit_pah |=> (pa_high_q == ($past(wdat) & pin_mux_pkg::MASK_PA_HIGH)))
    else $error("port A high write not stored");
  AST_RESET_CLEAR: assert property (
    @(posedge REF_CLK) $past(RST) |-> (pa_low_q == pin_mux_pkg::RST_SEL
                                      && pb_high_q == pin_mux_pkg::RST_SEL))
    else $error("selection not cleared by reset");

endmodule

// ==== sim/tb_port_abc_function_select_mux.sv ====
// Testbench: bus access, read-back masks and role decode of the small, medium and large port A/B/C mux
`timescale 1ns/10ps
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin errors++; \
  $display("wrong value %s expected %h seen %h", n, e, s); end end
module tb_port_abc_function_select_mux;
  // ==========================================================================
  // Signals and bench model
  // ==========================================================================
  logic                    REF_CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP;
  logic [31:0]             HADDR, HWDATA, HRDATA, rd, wd;
  logic [1:0]              HTRANS;
  logic [2:0]              HSIZE;
  logic [15:0]             ANALOG_EN, an;  // Analog routing and its model
  pin_mux_pkg::pin_roles_t PIN_ROLES;
  pin_mux_pkg::gpio_map_t  GPIO_EN;
  logic [14:0]             roles;          // Model of the role vector
  logic [31:0]             rd_s, rd_m;     // Read data, small and medium
  logic [15:0]             an_s, an_m;     // Analog routing, small and medium
  logic [15:0]             xs, xm;         // Analog model, small and medium
  logic [3:0]              xg;             // Model of PB6 and PC6..PC4 I/O flags
  pin_mux_pkg::pin_roles_t roles_s, roles_m; // Roles, small and medium
  pin_mux_pkg::gpio_map_t  gpio_s, gpio_m;   // I/O flags, small and medium
  logic [7:0]              msk_s [6] = '{8'hFC, 8'h3F, 8'hFF, 8'h03, 8'h00, 8'h0F};
  logic [7:0]              msk_m [6] = '{8'hFC, 8'h3F, 8'hFF, 8'h33, 8'h00, 8'h3F};
  logic [7:0]              mdl [6];        // Model copy of the registers
  logic [7:0]              msk [6] = '{8'hFC, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  integer                  errors = 0, check_count = 0, seed = 32'hf624960c;
  // ==========================================================================
  // Device, its bus ready looped back as HREADY of all three slaves
  // ==========================================================================
  port_abc_function_select_mux #(.VARIANT(pin_mux_pkg::VAR_LARGE)) u_dut (
    .REF_CLK(REF_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PIN_ROLES(PIN_ROLES),
    .ANALOG_EN(ANALOG_EN), .GPIO_EN(GPIO_EN));
  // Small and medium variants on the same bus, read data kept apart
  port_abc_function_select_mux #(.VARIANT(pin_mux_pkg::VAR_SMALL)) u_dut_s (
    .REF_CLK(REF_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(rd_s), .HREADYOUT(), .HRESP(), .PIN_ROLES(roles_s),
    .ANALOG_EN(an_s), .GPIO_EN(gpio_s));
  port_abc_function_select_mux #(.VARIANT(pin_mux_pkg::VAR_MEDIUM)) u_dut_m (
    .REF_CLK(REF_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(rd_m), .HREADYOUT(), .HRESP(), .PIN_ROLES(roles_m),
    .ANALOG_EN(an_m), .GPIO_EN(gpio_m));
  // Free-running clock at 100 MHz
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  // Field equals code
  function automatic logic fsel(input logic [7:0] v, input int p, input logic [1:0] c);
    return v[p+:2] == c;
  endfunction
  // Verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Edge with ready high, bounded
  task automatic wait_rdy;
    integer n;
    n = 0;
    do begin @(posedge REF_CLK); n++; end while (HREADYOUT !== 1'b1 && n < 50);
    if (n >= 50) begin errors++; end_sim(); end
  endtask
  // One single word transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    HSEL <= 1'b1; HTRANS <= 2'h2; HADDR <= {24'h000000, a}; HWRITE <= w; HSIZE <= 3'h2;
    wait_rdy();
    HTRANS <= 2'h0; HWDATA <= d;
    wait_rdy();
    r = HRDATA;
    `CHK("response", 1'b0, HRESP)
  endtask
  // Expected outputs from the model registers
  task automatic predict;
    roles = {fsel(mdl[0], 6, 2), fsel(mdl[0], 4, 2), fsel(mdl[0], 2, 2), fsel(mdl[0], 6, 3),
             fsel(mdl[0], 4, 3), fsel(mdl[0], 2, 3), fsel(mdl[1], 4, 3), !fsel(mdl[1], 4, 3),
             mdl[1][3:2] < 2'h2, fsel(mdl[1], 2, 2), mdl[3][1:0] < 2'h2, fsel(mdl[3], 0, 2),
             !fsel(mdl[3], 4, 3), 2'b00};
    an = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      an[4 + i] = fsel(mdl[3], 2 * i, 3);
      an[8 + i] = fsel(mdl[4], 2 * i, 3);
    end
    `CHK("roles", roles, PIN_ROLES)
    `CHK("analog", an, ANALOG_EN)
    `CHK("gpio c", ~an[11:8], GPIO_EN.portc[3:0])
    // Small and medium: UART roles, analog channels and I/O flags
    xs = {9'h000, fsel(mdl[5], 2, 3), fsel(mdl[5], 0, 3), an[4], 4'h0};
    xm = {7'h00, fsel(mdl[5], 4, 3), fsel(mdl[5], 2, 3), fsel(mdl[5], 0, 3),
          fsel(mdl[3], 4, 3), an[4], 4'h0};
    xg = {!fsel(mdl[3], 4, 3), !fsel(mdl[5], 4, 3), mdl[5][3:2] < 2'h2, mdl[5][1:0] < 2'h2};
    `CHK("roles s", {roles[14:3], 1'b0, fsel(mdl[5], 2, 2), fsel(mdl[5], 0, 2)}, roles_s)
    `CHK("roles m", {roles[14:3], 1'b0, fsel(mdl[5], 2, 2), fsel(mdl[5], 0, 2)}, roles_m)
    `CHK("analog s", xs, an_s)
    `CHK("analog m", xm, an_m)
    `CHK("gpio s", {2'b11, xg[1:0]}, {gpio_s.portb[6], gpio_s.portc[6:4]})
    `CHK("gpio m", xg, {gpio_m.portb[6], gpio_m.portc[6:4]})
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    RST = 1'b1; HSEL = 1'b0; HADDR = '0; HTRANS = 2'h0; HWRITE = 1'b0; HSIZE = 3'h2;
    HWDATA = '0;
    for (int i = 0; i < 6; i++) mdl[i] = 8'h00;
    repeat (16) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    // Reset values, offset 0x18 unmapped
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, 8'(4 * i), 32'h0, rd);
      `CHK("reset read", 32'h00000000, rd)
      `CHK("reset read sm", 64'h0000000000000000, {rd_s, rd_m})
    end
    predict();
    $display("test reset done");
    // Random writes with an idle cycle between transfers, read-back, then decoded outputs
    // Fields rewritten while no peripheral runs port direction lies outside
    for (int k = 0; k < 40; k++) begin
      for (int i = 0; i < 7; i++) begin
        wd = $random(seed);
        xfer(1'b1, 8'(4 * i), wd, rd);
        if (i < 6) mdl[i] = wd[7:0] & msk[i];
      end
      for (int i = 0; i < 7; i++) begin
        xfer(1'b0, 8'(4 * i), 32'h0, rd);
        `CHK("read back", {24'h000000, (i < 6) ? mdl[i] : 8'h00}, rd)
        `CHK("read back s", {24'h000000, (i < 6) ? mdl[i] & msk_s[i] : 8'h00}, rd_s)
        `CHK("read back m", {24'h000000, (i < 6) ? mdl[i] & msk_m[i] : 8'h00}, rd_m)
      end
      predict();
    end
    $display("test random select done");
    end_sim();
  end
endmodule
